// ===== shared/sra_pkg.sv
// constants for the serial register-access slave
// assumes a 250 MHz core clock and a 12.5 MHz maximum serial clock
package sra_pkg;

    // page layout: one byte address selects among 256 bytes
    localparam int PAGE_BYTES = 256;
    localparam int ADDR_W = 8;

    // global interface registers
    localparam logic [7:0] ADDR_PAGE = 8'hFF;
    localparam logic [7:0] ADDR_STATUS = 8'hFE;
    localparam logic [7:0] ADDR_DATA = 8'hF0;

    // status register bit positions
    localparam int STAT_XFER = 7;
    localparam int STAT_RDRDY = 5;
    localparam int STAT_MDIO = 2;

    // command byte fields
    localparam int CMD_MODE = 4;
    localparam int CMD_RW = 0;
    localparam logic [2:0] CMD_NORMAL_TAG = 3'h3;
    localparam logic [2:0] DEV_SELECT = 3'h0;
    localparam logic [7:0] OP_NORMAL_READ = 8'h60;
    localparam logic [7:0] OP_NORMAL_WRITE = 8'h61;
    localparam logic [7:0] OP_FAST_READ = 8'h10;

    // reset values
    localparam logic [7:0] PAGE_RESET = 8'h00;

    // timing: serial clock limit against the core clock
    localparam int CLK_PERIOD_PS = 4000;
    localparam int SCK_MIN_PERIOD_PS = 80000;
    localparam int SCK_HALF_CYC = SCK_MIN_PERIOD_PS / 2 / CLK_PERIOD_PS;
    localparam int SYNC_STAGES = 2;

    typedef enum logic [2:0] {
        ST_IDLE,
        ST_CMD,
        ST_ADDR,
        ST_DATA,
        ST_SKIP
    } sra_state_t;

endpackage : sra_pkg

// ===== shared/sra_link_if.sv
// synchronised serial-link events passed from the front end to the core
// assumes both ends run on the same core clock
`timescale 1ns/1ps
interface sra_link_if;
    logic sck_rise;
    logic sck_fall;
    logic ss_act;
    logic ss_start;
    logic ss_end;
    logic mosi;
    logic strap;

    modport front (
        output sck_rise, sck_fall, ss_act, ss_start, ss_end, mosi, strap
    );
    modport core (
        input sck_rise, sck_fall, ss_act, ss_start, ss_end, mosi, strap
    );
endinterface : sra_link_if

// ===== core/sra_sync_front.sv
// two-stage synchronisers and edge finders for the serial pins and strap
// assumes the pins are asynchronous to CLK
`timescale 1ns/1ps
module sra_sync_front (
    input wire logic clk,
    input wire logic rst,
    input wire logic sck_pin,
    input wire logic ss_n_pin,
    input wire logic mosi_pin,
    input wire logic strap_pin,
    sra_link_if.front link
);
    logic [3:0] meta;
    logic [3:0] sync;
    logic sck_prev;
    logic ss_prev;

    // first stage feeds only the second stage
    // no reset: the strap must already be settled when reset lifts
    always_ff @(posedge clk) begin
        meta <= {strap_pin, mosi_pin, ss_n_pin, sck_pin};
        sync <= meta;
    end

    // idle levels: clock high, select released
    always_ff @(posedge clk) begin
        if (rst) begin
            sck_prev <= 1'b1;
            ss_prev <= 1'b1;
        end else begin
            sck_prev <= sync[0];
            ss_prev <= sync[1];
        end
    end

    assign link.sck_rise = sync[0] & ~sck_prev;
    assign link.sck_fall = ~sync[0] & sck_prev;
    assign link.ss_act = ~sync[1];
    assign link.ss_start = ~sync[1] & ss_prev;
    assign link.ss_end = sync[1] & ~ss_prev;
    assign link.mosi = sync[2];
    assign link.strap = sync[3];
endmodule : sra_sync_front

// ===== core/sra_byte_buf.sv
// small byte buffer holding one fetched register image
// write and read on the core clock; read data is registered
`timescale 1ns/1ps
module sra_byte_buf #(
    parameter int DEPTH = 8,
    parameter int IW = $clog2(DEPTH)
) (
    input wire logic clk,
    input wire logic we,
    input wire logic [IW-1:0] waddr,
    input wire logic [7:0] wdata,
    input wire logic [IW-1:0] raddr,
    output logic [7:0] rdata
);
    logic [7:0] mem [DEPTH];

    always_ff @(posedge clk) begin
        if (we) begin
            mem[waddr] <= wdata;
        end
    end

    always_ff @(posedge clk) begin
        rdata <= mem[raddr];
    end
endmodule : sra_byte_buf

// ===== core/sra_spi_slave.sv
// serial register-access slave: mode 3 link to a paged register space
// assumes an internal byte-wide register port that answers with REG_ACK
//
// Overview of operation
// - register space is paged; 8-bit address picks one of 256 bytes
// - slave works only when the select strap reads high after reset
// - serial clock up to 12.5 MHz; oversampled by the 250 MHz core
// - device is slave only; master makes clock and select
// - serial clock idles high; polarity fixed
// - outputs change on clock fall, inputs sampled on clock rise
// - reads return status and register contents on the slave line
// - first byte command, second byte address, rest data
// - bit 4 low means normal command, top bits must be 011
// - bit 4 high: top bits offset the read start; no fast write
// - device select field must be 000
// - command bit 0: 0 read, 1 write
// - command counts only while select is active
// - byte address advances by one per data byte
// - releasing select ends the transaction
// - phy data polled over MDIO is read through this slave
// - page at FF, data window at F0, status at FE
// - status bit 7 busy, bit 5 read data ready, bit 2 MDIO busy
// - normal read 60, normal write 61, fast read 10
`timescale 1ns/1ps
module sra_spi_slave #(
    parameter int NBYTES = 8,
    parameter int IW = $clog2(NBYTES)
) (
    // clock and reset
    input wire logic CLK,
    input wire logic RST,
    // configuration strap
    input wire logic INTERFACE_SELECT_STRAP,
    output logic SPI_ENABLED,
    // serial link
    input wire logic SCK,
    input wire logic SS_N,
    input wire logic MOSI,
    output logic MISO,
    output logic MISO_OE,
    // internal register port
    output logic REG_REQ,
    output logic REG_WE,
    output logic [7:0] REG_PAGE,
    output logic [7:0] REG_ADDR,
    output logic [7:0] REG_WDATA,
    input wire logic REG_ACK,
    input wire logic [7:0] REG_RDATA,
    // phy polling engine
    output logic MDIO_START,
    input wire logic MDIO_DONE
);
    sra_link_if link ();

    sra_pkg::sra_state_t state;
    logic strap_taken, is_fast, is_write, first_data, fast_data;
    logic sending_data, busy, rd_ready, mdio_busy, eng_we;
    logic active, byte_done, cmd_ok, rd_go, wr_go, buf_spi_we, eng_ld;
    logic [2:0] bitcnt;
    logic [7:0] rx, tx, cmd, addr, page, eng_addr, eng_wdata;
    logic [7:0] buf_rdata, status, tx_sel, rx_byte;
    logic [IW-1:0] idx, eng_cnt;

    sra_sync_front u_front (
        .clk(CLK),
        .rst(RST),
        .sck_pin(SCK),
        .ss_n_pin(SS_N),
        .mosi_pin(MOSI),
        .strap_pin(INTERFACE_SELECT_STRAP),
        .link(link)
    );

    // strap is caught once, just after reset release
    always_ff @(posedge CLK) begin
        if (RST) begin
            strap_taken <= 1'b0;
            SPI_ENABLED <= 1'b0;
        end else if (!strap_taken) begin
            strap_taken <= 1'b1;
            SPI_ENABLED <= link.strap;
        end
    end

    assign active = SPI_ENABLED & link.ss_act;
    assign byte_done = active & link.sck_rise & (bitcnt == 3'h7);
    assign rx_byte = {rx[6:0], link.mosi};
    assign cmd_ok = (rx_byte[3:1] == sra_pkg::DEV_SELECT) &
        (rx_byte[sra_pkg::CMD_MODE] ? !rx_byte[sra_pkg::CMD_RW]
         : rx_byte[7:5] == sra_pkg::CMD_NORMAL_TAG);

    // receive shift on rising edges only
    always_ff @(posedge CLK) begin
        if (RST || !active) begin
            bitcnt <= 3'h0;
            rx <= 8'h00;
        end else if (link.sck_rise) begin
            bitcnt <= bitcnt + 3'h1;
            rx <= rx_byte;
        end
    end

    // byte sequencing: command, address, then data
    always_ff @(posedge CLK) begin
        if (RST || !SPI_ENABLED) begin
            state <= sra_pkg::ST_IDLE;
        end else if (link.ss_end || !link.ss_act) begin
            state <= sra_pkg::ST_IDLE;
        end else if (link.ss_start) begin
            state <= sra_pkg::ST_CMD;
        end else if (byte_done) begin
            unique case (state)
                sra_pkg::ST_CMD: begin
                    state <= cmd_ok ? sra_pkg::ST_ADDR : sra_pkg::ST_SKIP;
                end
                sra_pkg::ST_ADDR: state <= sra_pkg::ST_DATA;
                default: state <= state;
            endcase
        end
    end

    always_ff @(posedge CLK) begin
        if (RST) begin
            cmd <= 8'h00;
            addr <= 8'h00;
        end else if (byte_done && state == sra_pkg::ST_CMD) begin
            cmd <= rx_byte;
        end else if (byte_done && state == sra_pkg::ST_ADDR) begin
            addr <= rx_byte;
        end
    end

    assign is_fast = cmd[sra_pkg::CMD_MODE];
    assign is_write = cmd[sra_pkg::CMD_RW];

    // in a read, an address byte outside the global block (any address for a fast read) starts an internal fetch
    assign rd_go = byte_done && state == sra_pkg::ST_ADDR && !is_write &&
        (is_fast || (rx_byte != sra_pkg::ADDR_PAGE &&
                     rx_byte != sra_pkg::ADDR_STATUS &&
                     rx_byte != sra_pkg::ADDR_DATA));
    assign wr_go = byte_done && state == sra_pkg::ST_DATA && is_write &&
        addr != sra_pkg::ADDR_PAGE && addr != sra_pkg::ADDR_STATUS &&
        addr != sra_pkg::ADDR_DATA;
    assign buf_spi_we = byte_done && state == sra_pkg::ST_DATA &&
        is_write && addr == sra_pkg::ADDR_DATA;

    // data byte index; fast reads start at the command's offset
    always_ff @(posedge CLK) begin
        if (RST) begin
            idx <= '0;
            first_data <= 1'b0;
        end else if (byte_done && state == sra_pkg::ST_ADDR) begin
            idx <= is_fast ? IW'(cmd[7:5]) : '0;
            first_data <= 1'b1;
        end else if (byte_done && state == sra_pkg::ST_DATA) begin
            first_data <= 1'b0;
            if (sending_data || is_write) begin
                idx <= idx + IW'(1);
            end
        end
    end

    // page register and MDIO start, both written over the link
    always_ff @(posedge CLK) begin
        if (RST) begin
            page <= sra_pkg::PAGE_RESET;
        end else if (byte_done && state == sra_pkg::ST_DATA && is_write &&
                     first_data && addr == sra_pkg::ADDR_PAGE) begin
            page <= rx_byte;
        end
    end

    assign MDIO_START = byte_done && state == sra_pkg::ST_DATA && is_write &&
        addr == sra_pkg::ADDR_STATUS && rx_byte[sra_pkg::STAT_MDIO];

    // start wins over a done arriving in the same cycle
    always_ff @(posedge CLK) begin
        if (RST) begin
            mdio_busy <= 1'b0;
        end else if (MDIO_START) begin
            mdio_busy <= 1'b1;
        end else if (MDIO_DONE) begin
            mdio_busy <= 1'b0;
        end
    end

    // internal access engine: one byte at a time, request held to ack
    always_ff @(posedge CLK) begin
        if (RST) begin
            busy <= 1'b0;
            rd_ready <= 1'b0;
            eng_we <= 1'b0;
            eng_cnt <= '0;
            eng_addr <= 8'h00;
            eng_wdata <= 8'h00;
        end else if (busy) begin
            if (REG_ACK) begin
                eng_addr <= eng_addr + 8'h01;
                eng_cnt <= eng_cnt + IW'(1);
                if (eng_we || eng_cnt == IW'(NBYTES - 1)) begin
                    busy <= 1'b0;
                    rd_ready <= !eng_we;
                end
            end
        end else if (rd_go) begin
            busy <= 1'b1;
            rd_ready <= 1'b0;
            eng_we <= 1'b0;
            eng_cnt <= '0;
            eng_addr <= rx_byte;
        end else if (wr_go) begin
            // new writes are dropped while busy; master polls first
            busy <= 1'b1;
            eng_we <= 1'b1;
            eng_addr <= addr + {{(8 - IW){1'b0}}, idx};
            eng_wdata <= rx_byte;
        end
    end

    assign REG_REQ = busy;
    assign REG_WE = eng_we;
    assign REG_PAGE = page;
    assign REG_ADDR = eng_addr;
    assign REG_WDATA = eng_wdata;
    assign eng_ld = busy & REG_ACK & !eng_we;

    sra_byte_buf #(.DEPTH(NBYTES), .IW(IW)) u_buf (
        .clk(CLK),
        .we(eng_ld | buf_spi_we),
        .waddr(eng_ld ? eng_cnt : idx),
        .wdata(eng_ld ? REG_RDATA : rx_byte),
        .raddr(idx),
        .rdata(buf_rdata)
    );

    assign status = (8'(busy) << sra_pkg::STAT_XFER) |
        (8'(rd_ready) << sra_pkg::STAT_RDRDY) |
        (8'(mdio_busy) << sra_pkg::STAT_MDIO);

    // byte to send next; dummy zeros outside read data
    always_comb begin
        tx_sel = 8'h00;
        if (state == sra_pkg::ST_DATA && !is_write) begin
            if (is_fast) begin
                tx_sel = fast_data ? buf_rdata : status;
            end else if (addr == sra_pkg::ADDR_STATUS) begin
                tx_sel = status;
            end else if (addr == sra_pkg::ADDR_PAGE) begin
                tx_sel = page;
            end else if (addr == sra_pkg::ADDR_DATA) begin
                tx_sel = buf_rdata;
            end
        end
    end

    // fast read switches to data after a status byte showing ready
    always_ff @(posedge CLK) begin
        if (RST || !active) begin
            fast_data <= 1'b0;
            sending_data <= 1'b0;
        end else if (link.sck_fall && bitcnt == 3'h0 &&
                     state == sra_pkg::ST_DATA) begin
            sending_data <= !is_fast || fast_data;
            fast_data <= fast_data | rd_ready;
        end
    end

    // transmit shift on falling edges; first fall of a byte loads it
    always_ff @(posedge CLK) begin
        if (RST || !active) begin
            tx <= 8'h00;
            MISO <= 1'b0;
        end else if (link.sck_fall) begin
            if (bitcnt == 3'h0) begin
                MISO <= tx_sel[7];
                tx <= {tx_sel[6:0], 1'b0};
            end else begin
                MISO <= tx[7];
                tx <= {tx[6:0], 1'b0};
            end
        end
    end

    // the pin is driven only inside a transaction
    assign MISO_OE = active;

    default clocking cb @(posedge CLK); endclocking
    default disable iff (RST);

    sequence seq_cmd_bad;
        byte_done && state == sra_pkg::ST_CMD && !cmd_ok;
    endsequence
    sequence seq_addr_done;
        byte_done && state == sra_pkg::ST_ADDR;
    endsequence
    AST_STRAP_GATES: assert property (!SPI_ENABLED |-> !MISO_OE &&
        !MISO && state == sra_pkg::ST_IDLE)
        else $error("slave active while disabled");
    AST_RELEASE_ENDS: assert property (link.ss_end |=>
        state == sra_pkg::ST_IDLE && !MISO_OE)
        else $error("transaction not ended by select release");
    AST_BAD_CMD_SKIP: assert property (seq_cmd_bad |=>
        state == sra_pkg::ST_SKIP)
        else $error("bad command byte was accepted");
    AST_FAST_OFFSET: assert property (seq_addr_done ##0 is_fast |=>
        idx == IW'($past(cmd[7:5])))
        else $error("fast read offset not applied");
    AST_INDEX_STEP: assert property (byte_done && state ==
        sra_pkg::ST_DATA && is_write |=> idx == $past(idx) + IW'(1))
        else $error("byte address did not advance");
    AST_PAGE_LOAD: assert property (byte_done && state ==
        sra_pkg::ST_DATA && is_write && first_data &&
        addr == sra_pkg::ADDR_PAGE |=> page == $past(rx_byte))
        else $error("page register not loaded");
    AST_FETCH_START: assert property (rd_go && !busy |=>
        REG_REQ && !REG_WE && !rd_ready ##0 status[sra_pkg::STAT_XFER])
        else $error("internal fetch did not start");
    AST_FETCH_DONE: assert property (busy && !eng_we && REG_ACK &&
        eng_cnt == IW'(NBYTES - 1) |=> rd_ready && !busy ##1 rd_ready)
        else $error("read ready flag not set after fetch");
    AST_MISO_ON_FALL: assert property ($changed(MISO) && active &&
        $past(active) |-> $past(link.sck_fall))
        else $error("MISO changed away from a falling edge");
    AST_MDIO_HOLD: assert property (MDIO_START ||
        (status[sra_pkg::STAT_MDIO] && !MDIO_DONE) |=>
        status[sra_pkg::STAT_MDIO])
        else $error("MDIO busy not held until done");
endmodule : sra_spi_slave

// ===== sim/sra_host_model.sv
// host-side serial master model driving mode 3 frames
// assumes the bench calls frame() and nothing else drives the pins
`timescale 1ns/1ps
module sra_host_model (
    // serial link
    output logic sck,
    output logic ss_n,
    output logic mosi,
    input wire logic miso
);
    // 48 ns period: quicker than the 80 ns limit, a margin test
    localparam time HALF = 24ns;

    initial begin
        sck = 1'b1;
        ss_n = 1'b1;
        mosi = 1'b0;
    end

    // bytes leave from tx[7:0] upward, each MSB first
    task automatic frame(input int n, input logic [63:0] tx,
                         output logic [63:0] rx);
        rx = '0;
        ss_n = 1'b0;
        #HALF;
        for (int i = 0; i < n; i++) begin
            for (int b = 7; b >= 0; b--) begin
                sck = 1'b0;
                mosi = tx[8*i+b];
                #HALF;
                sck = 1'b1;
                rx[8*i+b] = miso;
                #HALF;
            end
        end
        ss_n = 1'b1;
        // released line shows no stale bit
        mosi = ~mosi;
        #240ns;
    endtask : frame
endmodule : sra_host_model

// ===== sim/spi_register_access_slave_tb.sv
// self-checking bench for the serial register-access slave
// assumes the host model above and a bench-side register responder
`timescale 1ns/1ps
module spi_register_access_slave_tb;
    typedef struct {
        int n;
        logic [63:0] tx;
        logic [15:0] exp;
        logic [15:0] m;
        logic [7:0] pg;
    } sra_row_t;

    logic clk, rst, strap, sck, ss_n, mosi, miso, miso_oe, spi_en;
    logic req, we, ack, mdio_start, mdio_done, oe_seen;
    logic [7:0] page, addr, wdata, rdata, wr_a, wr_d;
    logic [63:0] rx;
    int n_fail, num_checks, n_wr, n_start, n0, k;
    sra_row_t rows [8] = '{
        '{3, 64'hFE60, 16'h0000, 16'hFFFF, 8'h00},
        '{3, 64'h10FF61, 16'h0000, 16'h0000, 8'h10},
        '{3, 64'hFF60, 16'h0010, 16'hFFFF, 8'h10},
        '{3, 64'h1260, 16'h0000, 16'hFFFF, 8'h10},
        '{3, 64'hFE60, 16'h0020, 16'hFFFF, 8'h10},
        '{4, 64'hF060, 16'h2423, 16'hFFFF, 8'h10},
        '{3, 64'hFE62, 16'h0000, 16'hFFFF, 8'h10},
        '{3, 64'hFF40, 16'h0000, 16'hFFFF, 8'h10}
    };

    sra_spi_slave #(.NBYTES(8)) i_dut (
        .CLK(clk), .RST(rst),
        .INTERFACE_SELECT_STRAP(strap), .SPI_ENABLED(spi_en),
        .SCK(sck), .SS_N(ss_n), .MOSI(mosi),
        .MISO(miso), .MISO_OE(miso_oe),
        .REG_REQ(req), .REG_WE(we), .REG_PAGE(page),
        .REG_ADDR(addr), .REG_WDATA(wdata),
        .REG_ACK(ack), .REG_RDATA(rdata),
        .MDIO_START(mdio_start), .MDIO_DONE(mdio_done)
    );

    sra_host_model i_host (
        .sck(sck), .ss_n(ss_n), .mosi(mosi), .miso(miso)
    );

    initial begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end

    // register space: acks every other cycle, data is address plus 11
    always @(posedge clk) begin
        #1;
        ack = req && !ack;
        rdata = addr + 8'h11;
        if (ack && we) begin
            n_wr++;
            wr_a = addr;
            wr_d = wdata;
        end
        if (mdio_start === 1'b1) n_start++;
        if (miso_oe === 1'b1) oe_seen = 1'b1;
    end

    task automatic chk(input string what, input logic [15:0] exp, got);
        num_checks++;
        if (got !== exp) begin
            n_fail++;
            $display("ERROR %s expected %h seen %h", what, exp, got);
        end
    endtask : chk

    task automatic do_reset(input logic s);
        @(posedge clk);
        #1 strap = s;
        rst = 1'b1;
        repeat (2) @(posedge clk);
        #1 rst = 1'b0;
        repeat (8) @(posedge clk);
        #1;
    endtask : do_reset

    task automatic rd_stat(input logic [7:0] exp);
        i_host.frame(3, 64'hFE60, rx);
        chk("status", 16'(exp), 16'(rx[23:16]));
    endtask : rd_stat

    task automatic report_and_stop;
        $display("checks %0d failures %0d", num_checks, n_fail);
        if (n_fail == 0 && num_checks > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask : report_and_stop

    initial begin
        rst = 1'b1;
        strap = 1'b1;
        ack = 1'b0;
        rdata = 8'h00;
        mdio_done = 1'b0;
        oe_seen = 1'b0;
        n_fail = 0;
        num_checks = 0;
        n_wr = 0;
        n_start = 0;
        do_reset(1'b1);
        chk("enabled", 16'h0001, 16'(spi_en));
        chk("page reset", 16'h0000, 16'(page));
        chk("req reset", 16'h0000, 16'(req));
        for (int i = 0; i < 8; i++) begin
            oe_seen = 1'b0;
            i_host.frame(rows[i].n, rows[i].tx, rx);
            chk("row data", rows[i].exp, rx[31:16] & rows[i].m);
            chk("row page", 16'(rows[i].pg), 16'(page));
            chk("row drive", 16'h0001, 16'(oe_seen));
            $display("row %0d done", i);
        end
        // fast read, offset 2 at address 30
        i_host.frame(7, 64'h3050, rx);
        k = 0;
        for (int j = 4; j >= 2; j--) if (rx[8*j+5] === 1'b1) k = j;
        chk("fast ready", 16'h0001, 16'(k != 0));
        chk("fast data", 16'h4443, rx[8*k+8 +: 16]);
        $display("fast read done");
        n0 = n_wr;
        i_host.frame(3, 64'h554011, rx);
        chk("fast write", 16'(n0), 16'(n_wr));
        i_host.frame(4, 64'hBBAA4061, rx);
        chk("write count", 16'(n0 + 2), 16'(n_wr));
        chk("write addr", 16'h0041, 16'(wr_a));
        chk("write data", 16'h00BB, 16'(wr_d));
        $display("write test done");
        i_host.frame(3, 64'h04FE61, rx);
        chk("mdio start", 16'h0001, 16'(n_start));
        // the finished internal write has cleared the ready flag
        rd_stat(8'h04);
        @(posedge clk);
        #1 mdio_done = 1'b1;
        @(posedge clk);
        #1 mdio_done = 1'b0;
        rd_stat(8'h00);
        $display("mdio test done");
        do_reset(1'b0);
        chk("disabled", 16'h0000, 16'(spi_en));
        oe_seen = 1'b0;
        i_host.frame(3, 64'hFE60, rx);
        chk("disabled drive", 16'h0000, 16'(oe_seen));
        do_reset(1'b1);
        chk("page reset", 16'h0000, 16'(page));
        $display("strap test done");
        report_and_stop();
    end
endmodule : spi_register_access_slave_tb
